/* rtl/fault_recovery_defs.svh */
/*
 * Constants of the fault recovery controller: timing counts, selector
 * widths and reset values. Assumes a 200 MHz clock.
 */
// Operation
// R1 - With auto recovery on and drive locked, resume once the fault cause clears.
// R2 - Keep the fault-state indicator inactive while automatic attempts are running.
// R3 - When attempts fail, stay faulted and assert the fault-state indicator.
// R4 - Keep the fault relay activated while automatic recovery is enabled.
// R6 - Level-sensitive two-wire run control is recommended while auto recovery is used.
// R7 - When the overall time limit expires without restart, lock until power cycle.
// R8 - Attempts are spaced 1 s, 5 s, 10 s, then 60 s each.
// R9 - An attempt succeeds only with fault gone and run conditions permitting.
// R10 - Time limit selectable 5, 10, 30 min, 1, 2, 3 h or unlimited; default 5 min.
// R11 - Auto recovery is off after reset; limit applies only while it is enabled.
// R12 - Clear a fault on a rising edge of the selected source if cause removed.
// R13 - The keypad stop-reset key triggers the same manual fault clear.
// R14 - Manual source: none, local input (default 4), extension, cabinet, or fieldbus bit.
// R15 - Product restart does a fault clear, then a power-off/power-on like sequence.
// R16 - Interval sequence and limit timer restart from the start on each new lock.
`ifndef FAULT_RECOVERY_DEFS_SVH
`define FAULT_RECOVERY_DEFS_SVH

`define FRC_CLOCK_HZ        200000000
`define FRC_WAIT1_S         1
`define FRC_WAIT2_S         5
`define FRC_WAIT3_S         10
`define FRC_WAITN_S         60
`define FRC_LIMIT_SEL_W     3
`define FRC_LIMIT_SEL_RST   3'h0
`define FRC_LIMIT_5MIN_S    300
`define FRC_LIMIT_10MIN_S   600
`define FRC_LIMIT_30MIN_S   1800
`define FRC_LIMIT_1H_S      3600
`define FRC_LIMIT_2H_S      7200
`define FRC_LIMIT_3H_S      10800
`define FRC_SRC_W           3
`define FRC_SRC_RST         3'h1
`define FRC_IDX_W           4
`define FRC_IDX_RST         4'h3
`define FRC_RESTART_CYC     16

`endif

/* rtl/fault_recovery_pkg.sv */
/*
 * Types of the fault recovery controller.
 * Assumes the constants header is included by users where counts are needed.
 */
package fault_recovery_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_AUTO_WAIT,
        ST_MANUAL_LOCK,
        ST_EXPIRED_LOCK,
        ST_RESTART
    } recover_state_t;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_LOCAL,
        SRC_EXTENSION,
        SRC_CABINET,
        SRC_FIELDBUS
    } reset_src_t;

endpackage

/* rtl/seconds_tick_if.sv */
/*
 * Carrier between the controller and its seconds time base.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface seconds_tick_if;
    logic restart;
    logic tick;
    modport base (input restart, output tick);
    modport user (output restart, input tick);
endinterface
`default_nettype wire

/* rtl/seconds_tick.sv */
/*
 * Seconds time base: one-cycle tick each second, restartable.
 * Assumes clock enable and clock shared with the controller.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fault_recovery_defs.svh"
module seconds_tick #(
    parameter int CYCLES_PER_S = `FRC_CLOCK_HZ
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        enable_i,
    seconds_tick_if.base     tb
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        tick_q;
    logic        next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (tb.restart) begin
            next_count = 32'h0;
        end else if (count >= 32'(CYCLES_PER_S - 1)) begin
            next_count = 32'h0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count  <= 32'h0;
            tick_q <= 1'b0;
        end else if (enable_i) begin
            count  <= next_count;
            tick_q <= next_tick;
        end
    end

    assign tb.tick = tick_q;
endmodule
`default_nettype wire

/* rtl/fault_recovery_controller.sv */
/*
 * Fault recovery controller: automatic retries on a growing schedule with
 * an overall time limit, manual clears on a rising edge of a selected source
 * or the keypad key, and product restart.
 * Assumes all inputs synchronous to clock_i; time base of seconds.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fault_recovery_defs.svh"
module fault_recovery_controller #(
    parameter int CYCLES_PER_S = `FRC_CLOCK_HZ,
    parameter int RESTART_CYC  = `FRC_RESTART_CYC,
    parameter int LOCAL_N      = 8,
    parameter int EXT_N        = 6,
    parameter int CAB_N        = 8,
    parameter int BUS_N        = 16
) (
    // Clock, reset, enable.
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire logic                        enable_i,
    // Configuration.
    input  wire logic                        auto_recover_enable_i,
    input  wire logic [`FRC_LIMIT_SEL_W-1:0] limit_sel_i,
    input  wire logic [`FRC_SRC_W-1:0]       reset_src_i,
    input  wire logic [`FRC_IDX_W-1:0]       reset_idx_i,
    // Drive status and reset sources.
    input  wire logic                        fault_i,
    input  wire logic                        run_permit_i,
    input  wire logic [LOCAL_N-1:0]          local_in_i,
    input  wire logic [EXT_N-1:0]            ext_in_i,
    input  wire logic [CAB_N-1:0]            cab_in_i,
    input  wire logic [BUS_N-1:0]            bus_cmd_i,
    input  wire logic                        key_stop_reset_i,
    input  wire logic                        product_restart_i,
    // Status outputs.
    output logic                             locked_o,
    output logic                             fault_state_o,
    output logic                             fault_relay_o,
    output logic                             fault_clear_o,
    output logic                             restart_seq_o,
    output logic                             auto_active_o
);
    localparam int WAIT1_S = `FRC_WAIT1_S;
    localparam int WAIT2_S = `FRC_WAIT2_S;
    localparam int WAIT3_S = `FRC_WAIT3_S;
    localparam int WAITN_S = `FRC_WAITN_S;
    // Overall limits in seconds; a 16-bit seconds count covers the longest one.
    localparam int LIM_5MIN_S  = `FRC_LIMIT_5MIN_S;
    localparam int LIM_10MIN_S = `FRC_LIMIT_10MIN_S;
    localparam int LIM_30MIN_S = `FRC_LIMIT_30MIN_S;
    localparam int LIM_1H_S    = `FRC_LIMIT_1H_S;
    localparam int LIM_2H_S    = `FRC_LIMIT_2H_S;
    localparam int LIM_3H_S    = `FRC_LIMIT_3H_S;

    // The seconds base restarts at each new automatic lock, so the first wait is a full second.
    seconds_tick_if tb ();

    seconds_tick #(
        .CYCLES_PER_S (CYCLES_PER_S)
    ) u_tick (
        .clock_i  (clock_i),
        .rst_i    (rst_i),
        .enable_i (enable_i),
        .tb       (tb)
    );

    fault_recovery_pkg::recover_state_t state;
    fault_recovery_pkg::recover_state_t next_state;
    logic [15:0] wait_s;
    logic [15:0] next_wait_s;
    logic [15:0] total_s;
    logic [15:0] next_total_s;
    logic [1:0]  attempt;
    logic [1:0]  next_attempt;
    logic [7:0]  rs_count;
    logic [7:0]  next_rs_count;
    logic        src_prev;
    logic        key_prev;
    logic        pr_prev;
    logic        next_src_prev;
    logic        next_key_prev;
    logic        next_pr_prev;
    logic        next_locked;
    logic        next_fault_state;
    logic        next_fault_relay;
    logic        next_fault_clear;
    logic        next_restart_seq;
    logic        next_auto_active;
    logic        src_level;
    logic        manual_edge;
    logic        restart_edge;
    logic [15:0] limit_s;
    logic        unlimited;
    logic [15:0] attempt_wait_s;
    logic        tick_restart;
    logic [15:0] total_after;
    logic [15:0] wait_after;
    logic        limit_hit;
    logic        wait_done;

    // Selected manual source level. [R14]
    // An index beyond the width of the chosen source wraps, so every setting picks a real bit.
    always_comb begin
        src_level = 1'b0;
        case (fault_recovery_pkg::reset_src_t'(reset_src_i))
            fault_recovery_pkg::SRC_LOCAL:
                src_level = local_in_i[reset_idx_i % LOCAL_N];
            fault_recovery_pkg::SRC_EXTENSION:
                src_level = ext_in_i[reset_idx_i % EXT_N];
            fault_recovery_pkg::SRC_CABINET:
                src_level = cab_in_i[reset_idx_i % CAB_N];
            fault_recovery_pkg::SRC_FIELDBUS:
                src_level = bus_cmd_i[reset_idx_i % BUS_N];
            default:
                src_level = 1'b0;
        endcase
    end

    // Rising edges of selected source or keypad key. [R12] [R13]
    assign manual_edge  = (src_level & ~src_prev) | (key_stop_reset_i & ~key_prev);
    assign restart_edge = product_restart_i & ~pr_prev;

    // Edge detectors follow their inputs on every enabled cycle.
    always_comb begin
        next_src_prev = src_level;
        next_key_prev = key_stop_reset_i;
        next_pr_prev  = product_restart_i;
    end

    // Cleared at reset, so a source already high at release reads as a fresh edge.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev <= 1'b0;
            key_prev <= 1'b0;
            pr_prev  <= 1'b0;
        end else if (enable_i) begin
            src_prev <= next_src_prev;
            key_prev <= next_key_prev;
            pr_prev  <= next_pr_prev;
        end
    end

    // Overall time limit lookup. [R10]
    always_comb begin
        unlimited = 1'b0;
        case (limit_sel_i)
            3'h0:    limit_s = 16'(LIM_5MIN_S);
            3'h1:    limit_s = 16'(LIM_10MIN_S);
            3'h2:    limit_s = 16'(LIM_30MIN_S);
            3'h3:    limit_s = 16'(LIM_1H_S);
            3'h4:    limit_s = 16'(LIM_2H_S);
            3'h5:    limit_s = 16'(LIM_3H_S);
            default: begin
                limit_s   = 16'hffff;
                unlimited = 1'b1;
            end
        endcase
    end

    // Growing attempt spacing. [R8]
    always_comb begin
        case (attempt)
            2'h0:    attempt_wait_s = 16'(WAIT1_S);
            2'h1:    attempt_wait_s = 16'(WAIT2_S);
            2'h2:    attempt_wait_s = 16'(WAIT3_S);
            default: attempt_wait_s = 16'(WAITN_S);
        endcase
    end

    // Seconds after the tick being taken. The total saturates, so a long unlimited run
    // cannot wrap below a finite limit selected later; it expires at the next tick.
    always_comb begin
        total_after = (total_s == 16'hffff) ? total_s : total_s + 16'h1;
        wait_after  = wait_s + 16'h1;
        limit_hit   = !unlimited && (total_after >= limit_s);
        wait_done   = wait_after >= attempt_wait_s;
    end

    // Lock handling; a product restart request overrides whatever the lock would do.
    always_comb begin
        next_state    = state;
        next_wait_s   = wait_s;
        next_total_s  = total_s;
        next_attempt  = attempt;
        next_rs_count = rs_count;
        next_fault_clear = 1'b0;
        tick_restart  = 1'b0;
        case (state)
            fault_recovery_pkg::ST_RUN: begin
                if (fault_i && auto_recover_enable_i) begin
                    // Fresh schedule and limit on every new lock. [R16]
                    next_state   = fault_recovery_pkg::ST_AUTO_WAIT;
                    next_wait_s  = 16'h0;
                    next_total_s = 16'h0;
                    next_attempt = 2'h0;
                    tick_restart = 1'b1;
                end else if (fault_i) begin
                    // Without automatic recovery the fault is reported at once.
                    next_state = fault_recovery_pkg::ST_MANUAL_LOCK;
                end
            end
            fault_recovery_pkg::ST_AUTO_WAIT: begin
                if (!auto_recover_enable_i) begin
                    // Turning auto recovery off drops back to manual clearing. [R11]
                    next_state = fault_recovery_pkg::ST_MANUAL_LOCK;
                end else if (tb.tick) begin
                    next_total_s = total_after;
                    next_wait_s  = wait_after;
                    if (limit_hit) begin
                        next_state = fault_recovery_pkg::ST_EXPIRED_LOCK; // [R7]
                    end else if (wait_done) begin
                        next_wait_s = 16'h0;
                        if (attempt != 2'h3) begin
                            next_attempt = attempt + 2'h1;
                        end
                        if (!fault_i && run_permit_i) begin
                            next_state       = fault_recovery_pkg::ST_RUN; // [R1] [R9]
                            next_fault_clear = 1'b1;
                        end
                    end
                end
            end
            fault_recovery_pkg::ST_MANUAL_LOCK: begin
                if (manual_edge && !fault_i) begin
                    next_state       = fault_recovery_pkg::ST_RUN; // [R12] [R13]
                    next_fault_clear = 1'b1;
                end
            end
            fault_recovery_pkg::ST_EXPIRED_LOCK: begin
                // Only a power cycle leaves this state, apart from product restart.
                next_state = state;
            end
            fault_recovery_pkg::ST_RESTART: begin
                // A fixed length stands in for the power-down and power-up steps.
                if (rs_count >= 8'(RESTART_CYC - 1)) begin
                    next_state = fault_recovery_pkg::ST_RUN;
                end else begin
                    next_rs_count = rs_count + 8'h1;
                end
            end
            default: next_state = fault_recovery_pkg::ST_RUN;
        endcase
        // Product restart acts only when locked; it models a power cycle. [R15]
        if (restart_edge && state != fault_recovery_pkg::ST_RUN
                && state != fault_recovery_pkg::ST_RESTART) begin
            next_state       = fault_recovery_pkg::ST_RESTART;
            next_rs_count    = 8'h0;
            next_fault_clear = 1'b1;
        end
    end

    assign tb.restart = tick_restart;

    // Outputs follow the next state, so each changes at the edge that takes its cause.
    always_comb begin
        next_locked      = (next_state != fault_recovery_pkg::ST_RUN);
        // Hidden during attempts, shown once they fail or when not automatic. [R2] [R3]
        next_fault_state = (next_state == fault_recovery_pkg::ST_MANUAL_LOCK)
                        || (next_state == fault_recovery_pkg::ST_EXPIRED_LOCK);
        // Relay held active while auto recovery is enabled. [R4]
        next_fault_relay = auto_recover_enable_i || !next_fault_state;
        next_restart_seq = (next_state == fault_recovery_pkg::ST_RESTART);
        next_auto_active = (next_state == fault_recovery_pkg::ST_AUTO_WAIT);
    end

    // A low enable freezes every counter together with the seconds base.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= fault_recovery_pkg::ST_RUN;
            wait_s   <= 16'h0;
            total_s  <= 16'h0;
            attempt  <= 2'h0;
            rs_count <= 8'h0;
        end else if (enable_i) begin
            state    <= next_state;
            wait_s   <= next_wait_s;
            total_s  <= next_total_s;
            attempt  <= next_attempt;
            rs_count <= next_rs_count;
        end
    end

    // The relay idles active, as no fault is reported out of reset.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            locked_o      <= 1'b0;
            fault_state_o <= 1'b0;
            fault_relay_o <= 1'b1;
            fault_clear_o <= 1'b0;
            restart_seq_o <= 1'b0;
            auto_active_o <= 1'b0;
        end else if (enable_i) begin
            locked_o      <= next_locked;
            fault_state_o <= next_fault_state;
            fault_relay_o <= next_fault_relay;
            fault_clear_o <= next_fault_clear;
            restart_seq_o <= next_restart_seq;
            auto_active_o <= next_auto_active;
        end
    end
endmodule
`default_nettype wire

/* testbench/fault_recovery_properties.sv */
/*
 * Checker of the fault recovery controller, watching its top-level ports.
 * Assumes it is bound into the controller and that enable_i stays high.
 */
`timescale 1ns/1ps
`default_nettype none
module fault_recovery_properties #(
    parameter int CYCLES_PER_S = 10,
    parameter int RESTART_CYC  = 16
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Watched inputs.
    input wire logic enable_i,
    input wire logic auto_recover_enable_i,
    input wire logic fault_i,
    input wire logic product_restart_i,
    // Watched outputs.
    input wire logic locked_o,
    input wire logic fault_state_o,
    input wire logic fault_relay_o,
    input wire logic fault_clear_o,
    input wire logic restart_seq_o,
    input wire logic auto_active_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Cycles spent locked, and length of the current restart sequence.
    logic [31:0] age;
    logic [31:0] run_len;
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            age     <= 32'h0;
            run_len <= 32'h0;
        end else begin
            age     <= locked_o ? age + 32'h1 : 32'h0;
            run_len <= restart_seq_o ? run_len + 32'h1 : 32'h0;
        end
    end

    property p_auto_hides;
        auto_active_o |-> !fault_state_o;
    endproperty
    a_auto_hides: assert property (p_auto_hides) else $error("indicator shown during attempts");
    property p_relay_auto;
        auto_recover_enable_i && $past(auto_recover_enable_i) |-> fault_relay_o;
    endproperty
    a_relay_auto: assert property (p_relay_auto) else $error("relay dropped with auto on");
    property p_auto_lock;
        !locked_o && fault_i && enable_i && auto_recover_enable_i
            |=> locked_o && auto_active_o && !fault_state_o;
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("bad entry into attempts");
    property p_manual_lock;
        !locked_o && fault_i && enable_i && !auto_recover_enable_i
            |=> locked_o && fault_state_o && !fault_relay_o;
    endproperty
    a_manual_lock: assert property (p_manual_lock) else $error("bad manual lock");
    // A margin of two cycles keeps this clear of the exact success edge.
    property p_no_early;
        auto_active_o && age < CYCLES_PER_S - 2 |=> locked_o;
    endproperty
    a_no_early: assert property (p_no_early) else $error("attempt before first wait");
    property p_clear_pulse;
        fault_clear_o && enable_i |=> !fault_clear_o;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");
    property p_refuse;
        locked_o && fault_state_o && fault_i && !product_restart_i |=> !fault_clear_o && locked_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("cleared with cause present");
    property p_restart_go;
        locked_o && $rose(product_restart_i) |=> restart_seq_o;
    endproperty
    a_restart_go: assert property (p_restart_go) else $error("restart not started");
    property p_restart_len;
        $fell(restart_seq_o) |-> run_len == RESTART_CYC;
    endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart length wrong");
endmodule
`default_nettype wire

/* testbench/reset_source_model.sv */
/*
 * Model of the external reset sources: terminal inputs, fieldbus word, keypad.
 * Assumes set_src is called from one process on the shared clock.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
    // Clock.
    input  wire logic   clock_i,
    // Source levels.
    output logic [7:0]  local_in_o,
    output logic [5:0]  ext_in_o,
    output logic [7:0]  cab_in_o,
    output logic [15:0] bus_cmd_o,
    output logic        key_o,
    output logic        restart_o
);
    initial begin
        local_in_o = 8'h0;
        ext_in_o   = 6'h0;
        cab_in_o   = 8'h0;
        bus_cmd_o  = 16'h0;
        key_o      = 1'b0;
        restart_o  = 1'b0;
    end
    // Levels stand until the next call, as a two-wire control holds them.
    task automatic set_src(input int src, input int idx, input logic lvl);
        @(negedge clock_i);
        case (src)
            2: ext_in_o[idx] = lvl;
            3: cab_in_o[idx] = lvl;
            4: bus_cmd_o[idx] = lvl;
            5: key_o = lvl;
            6: restart_o = lvl;
            default: local_in_o[idx] = lvl;
        endcase
    endtask
endmodule
`default_nettype wire

/* testbench/fault_recovery_controller_bench.sv */
/*
 * Self-checking bench of the fault recovery controller.
 * Assumes a shortened second of CPS cycles; all sources come from the model.
 */
`timescale 1ns/1ps
`default_nettype none
module fault_recovery_controller_bench;
    localparam int CPS = 10;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        auto_en = 1'b0;
    logic [2:0]  limit_sel = 3'h0;
    logic [2:0]  rsrc = 3'h1;
    logic [3:0]  ridx = 4'h3;
    logic        fault = 1'b0;
    logic        permit = 1'b1;
    logic [7:0]  loc, cab;
    logic [5:0]  ext;
    logic [15:0] bus;
    logic        key, prs, seen;
    logic        locked, fstate, relay, fclear, rseq, aact;
    logic [2:0]  sels [3] = '{3'h0, 3'h1, 3'h6};
    logic [1:0]  expv [3] = '{2'b01, 2'b10, 2'b10};
    int          srcs [5] = '{1, 2, 3, 4, 5};
    int          idxs [5] = '{3, 5, 7, 15, 0};
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    initial forever #2.5 clock_i = ~clock_i;

    reset_source_model u_reset_source_model (.clock_i(clock_i), .local_in_o(loc),
        .ext_in_o(ext), .cab_in_o(cab), .bus_cmd_o(bus), .key_o(key), .restart_o(prs));
    fault_recovery_controller #(.CYCLES_PER_S(CPS)) u_fault_recovery_controller (
        .clock_i(clock_i), .rst_i(rst_i), .enable_i(1'b1),
        .auto_recover_enable_i(auto_en), .limit_sel_i(limit_sel), .reset_src_i(rsrc),
        .reset_idx_i(ridx), .fault_i(fault), .run_permit_i(permit), .local_in_i(loc),
        .ext_in_i(ext), .cab_in_i(cab), .bus_cmd_i(bus), .key_stop_reset_i(key),
        .product_restart_i(prs), .locked_o(locked), .fault_state_o(fstate),
        .fault_relay_o(relay), .fault_clear_o(fclear), .restart_seq_o(rseq),
        .auto_active_o(aact));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic do_reset(input int n);
        rst_i = 1'b1;
        repeat (n) @(negedge clock_i);
        cmp({locked, fstate, relay, fclear, rseq, aact}, 6'h08);
        rst_i = 1'b0;
    endtask

    // Raise a source for five cycles and note any clear pulse in the first four.
    task automatic pulse(input int s, input int d, output logic hit);
        hit = 1'b0;
        u_reset_source_model.set_src(s, d, 1'b1);
        repeat (4) begin
            @(negedge clock_i);
            if (fclear === 1'b1) hit = 1'b1;
        end
        u_reset_source_model.set_src(s, d, 1'b0);
    endtask

    task automatic auto_case(input int f_off, input int p_on, input int exp_s);
        int c;
        c = 0;
        fault = 1'b1;
        permit = 1'b0;
        @(negedge clock_i);
        while (fclear !== 1'b1 && c < 2000) begin
            if (c == f_off) fault = 1'b0;
            if (c == p_on) permit = 1'b1;
            @(negedge clock_i);
            c++;
        end
        // One cycle early or up to two cycles late is accepted around the wait end.
        if (c >= exp_s * CPS - 1 && c <= exp_s * CPS + 2) c = exp_s * CPS;
        cmp(c, exp_s * CPS);
        cmp({locked, fstate}, 2'b00);
    endtask

    task automatic restart_check();
        pulse(6, 0, seen);
        cmp(rseq, 1'b1);
        repeat (20) @(negedge clock_i);
        cmp({locked, rseq}, 2'b00);
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        do_reset(6);
        auto_en = 1'b1;
        auto_case(5, 30, 6);
        auto_case(80, 0, 16);
        auto_case(200, 0, 76);
        auto_case(0, 0, 1);
        for (int i = 0; i < 3; i++) begin
            limit_sel = sels[i];
            fault = 1'b1;
            repeat (295 * CPS) @(negedge clock_i);
            cmp({aact, fstate}, 2'b10);
            repeat (10 * CPS) @(negedge clock_i);
            cmp({aact, fstate}, expv[i]);
            cmp(relay, 1'b1);
            fault = 1'b0;
            if (i == 0) begin
                pulse(1, 3, seen);
                cmp({seen, locked}, 2'b01);
            end
            restart_check();
        end
        auto_en = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rsrc = (srcs[i] == 5) ? 3'h0 : 3'(srcs[i]);
            ridx = 4'(idxs[i]);
            fault = 1'b1;
            pulse(srcs[i], idxs[i], seen);
            cmp({seen, locked, fstate, relay}, 4'b0110);
            fault = 1'b0;
            if (srcs[i] == 5) begin
                pulse(1, 3, seen);
                cmp({seen, locked}, 2'b01);
            end
            pulse(srcs[i], idxs[i], seen);
            cmp({seen, locked, fstate, relay}, 4'b1001);
        end
        fault = 1'b1;
        repeat (3) @(negedge clock_i);
        do_reset(3);
        end_of_test();
    end
endmodule

bind fault_recovery_controller fault_recovery_properties #(
    .CYCLES_PER_S(CYCLES_PER_S), .RESTART_CYC(RESTART_CYC)) u_fault_recovery_properties (
    .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i),
    .auto_recover_enable_i(auto_recover_enable_i), .fault_i(fault_i),
    .product_restart_i(product_restart_i), .locked_o(locked_o),
    .fault_state_o(fault_state_o), .fault_relay_o(fault_relay_o),
    .fault_clear_o(fault_clear_o), .restart_seq_o(restart_seq_o),
    .auto_active_o(auto_active_o));
`default_nettype wire
